// file: logic/audf_pkg.sv
// Purpose: constants for the authentication-peripheral filter switch
// Assumes: 40 MHz ref_clk, 32-bit register port, four computer channels
// Notes: byte addresses, one aligned word per register
package audf_pkg;
  localparam int CLK_KHZ = 40000; // clock rate in kHz
  localparam int NCH = 4; // computer channels
  // register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CRIT = 8'h04;
  localparam logic [7:0] A_WL_CSP = 8'h08;
  localparam logic [7:0] A_WL_ID = 8'h0c;
  localparam logic [7:0] A_WL_SER = 8'h10;
  localparam logic [7:0] A_BL_ID = 8'h14;
  localparam logic [7:0] A_TRAFFIC = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h1c;
  localparam logic [7:0] A_FAIL_TIME = 8'h20;
  // criteria enable bit positions in A_CRIT
  localparam int CR_CLS = 0;
  localparam int CR_SUB = 1;
  localparam int CR_PROTO = 2;
  localparam int CR_PID = 3;
  localparam int CR_VID = 4;
  localparam int CR_SER = 5;
  localparam int CR_BL_EN = 6;
  localparam int CR_W = 7;
  // fixed filter: smart-card class code, revisions in bcd, must be bus powered
  localparam logic [7:0] CARD_CLASS = 8'h0b;
  localparam logic [15:0] CARD_REV_A = 16'h0110;
  localparam logic [15:0] CARD_REV_B = 16'h0100;
  // power dip: supply held off and discharged at least this long
  localparam int DIP_US = 100;
  localparam int DIP_CYC = (DIP_US * CLK_KHZ + 999) / 1000;
  // defaults sequence blink phase and blink half period
  localparam int BLINK_MS = 2000;
  localparam int BLINK_CYC = BLINK_MS * CLK_KHZ;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;
  // main control states, one-hot
  typedef enum logic [3:0] {
    ST_TEST = 4'h1,
    ST_RUN = 4'h2,
    ST_FAIL = 4'h4,
    ST_BLINK = 4'h8
  } audf_st_t;
  // qualification states, one-hot
  typedef enum logic [3:0] {
    Q_IDLE = 4'h1,
    Q_WAIT = 4'h2,
    Q_OK = 4'h4,
    Q_REJ = 4'h8
  } audf_q_t;
endpackage

// file: logic/audf_switch.sv
// Purpose: qualifies an authentication peripheral and switches it to a computer
// Assumes: enumeration details come from the qualifier core as a pulse with data
// Notes: only routing control here; peripheral traffic never enters this block
`timescale 1ns/100ps

module audf_switch import audf_pkg::*; #(
  parameter int DIP_CYCLES = DIP_CYC,
  parameter int BLINK_CYCLES = BLINK_CYC,
  parameter int BLINK_HALF_CYCLES = BLINK_HALF_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  input wire logic admin_auth,
  input wire logic [NCH-1:0] btn_sel,
  input wire logic btn_freeze,
  input wire logic btn_default,
  input wire logic selftest_done,
  input wire logic selftest_pass,
  input wire logic tamper,
  input wire logic dev_attach,
  input wire logic enum_valid,
  input wire logic [7:0] enum_class,
  input wire logic [7:0] enum_subclass,
  input wire logic [7:0] enum_protocol,
  input wire logic [15:0] enum_vid,
  input wire logic [15:0] enum_pid,
  input wire logic [31:0] enum_serial,
  input wire logic [15:0] enum_rev,
  input wire logic enum_bus_powered,
  input wire logic vbus_low,
  output logic mode_to_mux,
  output logic [NCH-1:0] mux_sel,
  output logic vbus_en,
  output logic vbus_discharge,
  output logic [NCH-1:0] led_chan,
  output logic led_freeze,
  output logic selftest_start,
  output logic reject_evt,
  output logic fail_log
);
  audf_st_t st_q; // main control state
  audf_q_t q_q; // qualification state
  logic cfg_q; // configurable filtration mode active
  logic loaded_q; // a list or traffic rule has been loaded
  logic [CR_W-1:0] crit_q; // criteria enables
  logic [23:0] wl_csp_q; // class, subclass, protocol
  logic [31:0] wl_id_q; // vid, pid
  logic [31:0] wl_ser_q; // serial number
  logic [31:0] bl_id_q; // black-listed vid, pid
  logic [NCH-1:0] block_q; // forbidden channels
  logic [NCH-1:0] sel_q; // selected channel, one-hot
  logic freeze_q; // freeze active
  logic dip_q; // power dip in progress
  logic [15:0] dip_cnt_q; // dip length counter
  logic [31:0] blink_cnt_q; // defaults blink phase counter
  logic [31:0] half_cnt_q; // blink half period counter
  logic blink_on_q; // blink phase of indicators
  logic [31:0] time_q; // free-running time tag
  logic [31:0] fail_time_q; // time tag of last self-test failure
  logic [NCH-1:0] mux_sel_q; // registered multiplexer select
  logic [31:0] rdata_q; // read data register
  logic match; // enumeration details pass the active filter
  logic chg_go; // accepted channel change
  logic run_ok; // normal operation, no tamper

  // true when exactly one bit is set
  function automatic logic one_hot(input logic [NCH-1:0] b);
    return (b != '0) && ((b & (b - NCH'(1))) == '0);
  endfunction

  // fixed filter or configured white and black lists
  always_comb begin
    logic wl;
    logic bl;
    wl = 1'b1;
    bl = 1'b0;
    if (cfg_q) begin
      // each enabled criterion must agree
      if (crit_q[CR_CLS] && enum_class != wl_csp_q[23:16]) wl = 1'b0;
      if (crit_q[CR_SUB] && enum_subclass != wl_csp_q[15:8]) wl = 1'b0;
      if (crit_q[CR_PROTO] && enum_protocol != wl_csp_q[7:0]) wl = 1'b0;
      if (crit_q[CR_VID] && enum_vid != wl_id_q[31:16]) wl = 1'b0;
      if (crit_q[CR_PID] && enum_pid != wl_id_q[15:0]) wl = 1'b0;
      if (crit_q[CR_SER] && enum_serial != wl_ser_q) wl = 1'b0;
      // black list adds a restriction on top
      bl = crit_q[CR_BL_EN] && {enum_vid, enum_pid} == bl_id_q;
      match = wl && !bl;
    end else begin
      // only bus-powered card-class devices
      match = enum_bus_powered && enum_class == CARD_CLASS &&
              (enum_rev == CARD_REV_A || enum_rev == CARD_REV_B);
    end
  end

  // only a front-panel button may change the channel
  assign chg_go = st_q == ST_RUN && !freeze_q && one_hot(btn_sel) && btn_sel != sel_q;
  assign run_ok = st_q == ST_RUN && !tamper;

  // main control: self-test, normal run, failure, defaults blink
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= ST_TEST;
    end else begin
      unique case (st_q)
        ST_TEST: begin
          if (selftest_done) st_q <= selftest_pass ? ST_RUN : ST_FAIL;
        end
        ST_RUN: begin
          if (tamper) st_q <= ST_FAIL;
          else if (btn_default) st_q <= ST_BLINK;
        end
        ST_FAIL: st_q <= ST_FAIL; // latched until power cycle
        ST_BLINK: begin
          if (blink_cnt_q == 32'(BLINK_CYCLES - 1)) st_q <= ST_TEST;
        end
        default: st_q <= ST_FAIL; // illegal code treated as failure
      endcase
    end
  end

  // retest request pulses as the blink phase ends
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      selftest_start <= 1'b0;
    end else begin
      selftest_start <= st_q == ST_BLINK && blink_cnt_q == 32'(BLINK_CYCLES - 1);
    end
  end

  // blink timers, all indicators together
  always_ff @(posedge ref_clk) begin
    if (rst || st_q != ST_BLINK) begin
      blink_cnt_q <= '0;
      half_cnt_q <= '0;
      blink_on_q <= 1'b1;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h1;
      if (half_cnt_q == 32'(BLINK_HALF_CYCLES - 1)) begin
        half_cnt_q <= '0;
        blink_on_q <= !blink_on_q;
      end else begin
        half_cnt_q <= half_cnt_q + 32'h1;
      end
    end
  end

  // time tag and failure record
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      time_q <= '0;
      fail_time_q <= '0;
      fail_log <= 1'b0;
    end else begin
      time_q <= time_q + 32'h1;
      fail_log <= st_q == ST_TEST && selftest_done && !selftest_pass;
      if (st_q == ST_TEST && selftest_done && !selftest_pass) fail_time_q <= time_q;
    end
  end

  // channel selection and freeze, cleared whenever not running
  always_ff @(posedge ref_clk) begin
    if (rst || st_q != ST_RUN) begin
      sel_q <= '0; // nothing chosen before the test passes
      freeze_q <= 1'b0;
    end else begin
      if (sel_q == '0) sel_q <= {{(NCH-1){1'b0}}, 1'b1}; // first channel after pass
      else if (chg_go) sel_q <= btn_sel;
      if (btn_freeze) freeze_q <= !freeze_q;
    end
  end

  // power dip on channel change: supply off, load shorts rail until low
  always_ff @(posedge ref_clk) begin
    if (rst || !run_ok) begin
      dip_q <= 1'b0;
      dip_cnt_q <= '0;
    end else if (chg_go && sel_q != '0) begin
      dip_q <= 1'b1;
      dip_cnt_q <= '0;
    end else if (dip_q) begin
      // both the minimum time and the low rail are needed
      if (dip_cnt_q >= 16'(DIP_CYCLES - 1) && vbus_low) dip_q <= 1'b0;
      else if (dip_cnt_q < 16'(DIP_CYCLES - 1)) dip_cnt_q <= dip_cnt_q + 16'h1;
    end
  end

  // peripheral supply switch and discharge load
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      vbus_en <= 1'b0;
      vbus_discharge <= 1'b0;
    end else begin
      vbus_en <= run_ok && !dip_q && !(chg_go && sel_q != '0);
      vbus_discharge <= run_ok && (dip_q || (chg_go && sel_q != '0));
    end
  end

  // qualification: qualifier first, then mux, recheck during session
  always_ff @(posedge ref_clk) begin
    if (rst || !run_ok || !dev_attach || dip_q) begin
      q_q <= Q_IDLE;
    end else begin
      unique case (q_q)
        Q_IDLE: q_q <= Q_WAIT; // route to qualifier on attach
        Q_WAIT: begin
          if (enum_valid) q_q <= match ? Q_OK : Q_REJ;
        end
        Q_OK: begin
          if (enum_valid && !match) q_q <= Q_REJ;
        end
        Q_REJ: q_q <= Q_REJ; // held until detach, a power dip, tamper or leaving normal run
        default: q_q <= Q_IDLE;
      endcase
    end
  end

  // rejection event toward the log
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reject_evt <= 1'b0;
    end else begin
      reject_evt <= run_ok && dev_attach && !dip_q && enum_valid && !match &&
                    (q_q == Q_WAIT || q_q == Q_OK);
    end
  end

  // multiplexer: only the selected, unforbidden channel, only when qualified
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mux_sel_q <= '0;
    end else if (run_ok && q_q == Q_OK && !dip_q && (sel_q & block_q) == '0) begin
      mux_sel_q <= sel_q;
    end else begin
      mux_sel_q <= '0;
    end
  end
  // switch only steers lines; no traffic is sampled or stored
  assign mux_sel = mux_sel_q;
  assign mode_to_mux = q_q == Q_OK;

  // indicators: dark in test and fail, blink together in defaults
  always_comb begin
    led_chan = '0;
    led_freeze = 1'b0;
    if (st_q == ST_RUN) begin
      led_chan = sel_q; // no dimming control exists
      led_freeze = freeze_q;
    end else if (st_q == ST_BLINK) begin
      led_chan = {NCH{blink_on_q}};
      led_freeze = blink_on_q;
    end
  end

  // register writes; defaults sequence restores factory settings
  always_ff @(posedge ref_clk) begin
    if (rst || st_q == ST_BLINK) begin
      cfg_q <= 1'b0;
      loaded_q <= 1'b0;
      crit_q <= '0;
      wl_csp_q <= '0;
      wl_id_q <= '0;
      wl_ser_q <= '0;
      bl_id_q <= '0;
      block_q <= '0;
    end else if (reg_we) begin
      unique case (reg_addr)
        A_CTRL: begin
          // configurable mode needs a login and a loaded
          if (reg_wdata[0] && admin_auth && loaded_q) cfg_q <= 1'b1;
          if (reg_wdata[1]) cfg_q <= 1'b0;
        end
        A_CRIT: crit_q <= reg_wdata[CR_W-1:0];
        A_WL_CSP: begin
          wl_csp_q <= reg_wdata[23:0];
          loaded_q <= 1'b1;
        end
        A_WL_ID: begin
          wl_id_q <= reg_wdata;
          loaded_q <= 1'b1;
        end
        A_WL_SER: begin
          wl_ser_q <= reg_wdata;
          loaded_q <= 1'b1;
        end
        A_BL_ID: begin
          bl_id_q <= reg_wdata;
          loaded_q <= 1'b1;
        end
        A_TRAFFIC: begin
          block_q <= reg_wdata[NCH-1:0];
          loaded_q <= 1'b1;
        end
        default: ; // unmapped or read-only: ignored
      endcase
    end
  end

  // read data, valid the cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk) begin
    if (rst || !reg_re) begin
      rdata_q <= '0;
    end else begin
      unique case (reg_addr)
        A_CTRL: rdata_q <= {30'h0, loaded_q, cfg_q};
        A_CRIT: rdata_q <= {25'h0, crit_q};
        A_WL_CSP: rdata_q <= {8'h0, wl_csp_q};
        A_WL_ID: rdata_q <= wl_id_q;
        A_WL_SER: rdata_q <= wl_ser_q;
        A_BL_ID: rdata_q <= bl_id_q;
        A_TRAFFIC: rdata_q <= {28'h0, block_q};
        A_STATUS: rdata_q <= {12'h0, freeze_q, dip_q, 2'h0, sel_q, q_q, 4'h0, st_q};
        A_FAIL_TIME: rdata_q <= fail_time_q;
        default: rdata_q <= '0;
      endcase
    end
  end
  assign reg_rdata = rdata_q;

  // assertions
  sequence s_chg;
    chg_go && sel_q != '0 && run_ok; // tamper in the same cycle wins over the dip
  endsequence
  sequence s_dip_out;
    !vbus_en && vbus_discharge;
  endsequence

  property p_test_dark;
    @(posedge ref_clk) disable iff (rst) st_q == ST_TEST |-> sel_q == '0 && led_chan == '0;
  endproperty
  a_test_dark: assert property (p_test_dark) else $error("selection shown before pass");

  property p_fail_iso;
    @(posedge ref_clk) disable iff (rst) st_q == ST_FAIL |=> mux_sel == '0 && !mode_to_mux;
  endproperty
  a_fail_iso: assert property (p_fail_iso) else $error("path open after failure");

  property p_attach;
    @(posedge ref_clk) disable iff (rst) $rose(dev_attach) |=> !mode_to_mux ##1 !mode_to_mux;
  endproperty
  a_attach: assert property (p_attach) else $error("attach went straight to mux");

  property p_dip;
    @(posedge ref_clk) disable iff (rst) s_chg |=> s_dip_out ##1 (dip_q && mux_sel == '0);
  endproperty
  a_dip: assert property (p_dip) else $error("no power dip on change");

  property p_freeze;
    @(posedge ref_clk) disable iff (rst)
      st_q == ST_RUN && freeze_q && !btn_freeze && sel_q != '0 |=> $stable(sel_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("selection moved under freeze");

  property p_recheck;
    @(posedge ref_clk) disable iff (rst)
      q_q == Q_OK && run_ok && dev_attach && !dip_q && enum_valid && !match
      |=> q_q == Q_REJ && reject_evt ##1 mux_sel == '0;
  endproperty
  a_recheck: assert property (p_recheck) else $error("mismatch not rejected");

  property p_cfg_admin;
    @(posedge ref_clk) disable iff (rst) $rose(cfg_q) |-> $past(admin_auth) && $past(loaded_q);
  endproperty
  a_cfg_admin: assert property (p_cfg_admin) else $error("config mode without login");

  property p_defaults;
    @(posedge ref_clk) disable iff (rst)
      st_q == ST_RUN && !tamper && btn_default |=> st_q == ST_BLINK ##1 !cfg_q && mux_sel == '0;
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults sequence not started");

  property p_fail_tag;
    @(posedge ref_clk) disable iff (rst)
      st_q == ST_TEST && selftest_done && !selftest_pass |=> fail_log && fail_time_q == $past(time_q);
  endproperty
  a_fail_tag: assert property (p_fail_tag) else $error("failure not time tagged");

  property p_lit;
    @(posedge ref_clk) disable iff (rst) st_q == ST_RUN && $past(st_q) == ST_RUN |-> $onehot(led_chan);
  endproperty
  a_lit: assert property (p_lit) else $error("channel indicator not lit");
endmodule

// file: tb/audf_periph_model.sv
// Purpose: behavioural authentication peripheral on the switched port
// Assumes: it enumerates only while its supply is switched on
// Notes: enum fields carry a moving filler outside the valid pulse
`timescale 1ns/100ps
module audf_periph_model #(
  parameter int ENUM_DLY = 6,
  parameter int DRAIN = 3
) (
  input wire logic ref_clk,
  input wire logic plug,
  input wire logic kick,
  input wire logic [104:0] desc,
  input wire logic vbus_en,
  input wire logic vbus_discharge,
  output logic dev_attach,
  output logic enum_valid = 1'b0,
  output logic [104:0] enum_bus,
  output logic vbus_low
);
  int lvl = 0; // rail charge in steps
  int cnt = 0; // cycles since power good
  logic done = 1'b0; // already enumerated this power cycle
  logic [7:0] pat = 8'h5a; // filler, so stale details never match
  assign dev_attach = plug;
  assign vbus_low = (lvl == 0);
  assign enum_bus = enum_valid ? desc : {{13{pat}}, pat[0]};
  // a floating rail keeps its charge, only the load drains it
  always @(posedge ref_clk) begin
    pat <= pat + 8'h3b;
    if (vbus_en) begin
      lvl <= DRAIN;
    end else if (vbus_discharge && lvl > 0) begin
      lvl <= lvl - 1;
    end
  end
  // enumerate once per attach and power-up, again when asked
  always @(posedge ref_clk) begin
    enum_valid <= 1'b0;
    if (!plug || !vbus_en || kick) begin
      cnt <= 0;
      done <= 1'b0;
    end else if (!done) begin
      if (cnt == ENUM_DLY) begin
        enum_valid <= 1'b1;
        done <= 1'b1;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// file: tb/tb.sv
// Purpose: self-checking bench for the authentication-peripheral switch
// Assumes: short dip and blink counts, one peripheral model on the port
// Notes: random descriptors mixed with hand-picked corner cases
`timescale 1ns/100ps
module tb import audf_pkg::*;;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic admin_auth = 1'b0;
  logic [NCH-1:0] btn_sel = 4'h0;
  logic btn_freeze = 1'b0;
  logic btn_default = 1'b0;
  logic selftest_done = 1'b0;
  logic selftest_pass = 1'b0;
  logic tamper = 1'b0;
  logic plug = 1'b0;
  logic kick = 1'b0;
  logic [104:0] desc = '0;
  wire logic [104:0] eb;
  wire logic dev_attach;
  wire logic enum_valid;
  wire logic vbus_low;
  logic [31:0] reg_rdata;
  logic mode_to_mux;
  logic [NCH-1:0] mux_sel;
  logic vbus_en;
  logic vbus_discharge;
  logic [NCH-1:0] led_chan;
  logic led_freeze;
  logic selftest_start;
  logic reject_evt;
  logic fail_log;
  int seed = 32'h298c9095;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  int rej_n = 0; // reject pulses seen
  int fail_n = 0; // failure log pulses seen
  int st_n = 0; // retest requests seen
  int k;
  logic [NCH-1:0] cur; // channel expected selected
  logic [31:0] rd_d;
  logic [31:0] r;
  logic ok;

  audf_switch #(.DIP_CYCLES(4), .BLINK_CYCLES(40), .BLINK_HALF_CYCLES(5)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .admin_auth(admin_auth),
    .btn_sel(btn_sel), .btn_freeze(btn_freeze), .btn_default(btn_default),
    .selftest_done(selftest_done), .selftest_pass(selftest_pass), .tamper(tamper),
    .dev_attach(dev_attach), .enum_valid(enum_valid), .enum_class(eb[104:97]),
    .enum_subclass(eb[96:89]), .enum_protocol(eb[88:81]), .enum_vid(eb[80:65]),
    .enum_pid(eb[64:49]), .enum_serial(eb[48:17]), .enum_rev(eb[16:1]),
    .enum_bus_powered(eb[0]), .vbus_low(vbus_low), .mode_to_mux(mode_to_mux),
    .mux_sel(mux_sel), .vbus_en(vbus_en), .vbus_discharge(vbus_discharge),
    .led_chan(led_chan), .led_freeze(led_freeze), .selftest_start(selftest_start),
    .reject_evt(reject_evt), .fail_log(fail_log));

  audf_periph_model u_dev (
    .ref_clk(ref_clk), .plug(plug), .kick(kick), .desc(desc), .vbus_en(vbus_en),
    .vbus_discharge(vbus_discharge), .dev_attach(dev_attach), .enum_valid(enum_valid),
    .enum_bus(eb), .vbus_low(vbus_low));

  // 40 MHz reference clock
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  // event counters and hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (reject_evt === 1'b1) rej_n <= rej_n + 1;
    if (fail_log === 1'b1) fail_n <= fail_n + 1;
    if (selftest_start === 1'b1) st_n <= st_n + 1;
    if (cycles >= 20000) begin
      fail_count = fail_count + 1;
      final_report();
    end
  end

  task automatic final_report();
    if (fail_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // fixed filter: card class, one of two revisions, bus powered
  function automatic logic card_ok(input logic [104:0] d);
    return d[104:97] == CARD_CLASS && (d[16:1] == CARD_REV_A || d[16:1] == CARD_REV_B) && d[0];
  endfunction

  function automatic logic [104:0] mk(input logic [7:0] c, input logic [15:0] v,
    input logic [15:0] p, input logic [15:0] rv, input logic bp);
    return {c, 8'h00, 8'h00, v, p, 32'h00000001, rv, bp};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic reset_dut();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
  endtask

  // one-cycle pulse: 0 channel, 1 freeze, 2 defaults, 3 self-test result
  task automatic press(input int b, input logic [3:0] v);
    @(posedge ref_clk);
    case (b)
      0: btn_sel <= v;
      1: btn_freeze <= 1'b1;
      2: btn_default <= 1'b1;
      default: begin
        selftest_done <= 1'b1;
        selftest_pass <= v[0];
      end
    endcase
    @(posedge ref_clk);
    btn_sel <= 4'h0;
    btn_freeze <= 1'b0;
    btn_default <= 1'b0;
    selftest_done <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_re <= 1'b0;
    #1;
    rd_d = reg_rdata;
  endtask

  // ask the peripheral to enumerate again, then let it settle
  task automatic reenum();
    @(posedge ref_clk);
    kick <= 1'b1;
    @(posedge ref_clk);
    kick <= 1'b0;
    tick(14);
  endtask

  task automatic wait_mux(input logic [3:0] e);
    for (int i = 0; i < 200 && mux_sel !== e; i++) tick(1);
    chk("mux_sel", mux_sel, e);
  endtask

  initial begin
    desc = mk(CARD_CLASS, 16'h1234, 16'h0001, CARD_REV_A, 1'b1);
    reset_dut();
    // buttons before the self-test are ignored and nothing lights
    for (int i = 0; i < 4; i++) press(0, 4'h1 << i);
    chk("led_chan", led_chan, 4'h0);
    chk("mux_sel", mux_sel, 4'h0);
    rd(A_STATUS);
    chk("state", rd_d[3:0], 4'h1);
    press(3, 4'h1);
    tick(2);
    chk("led_chan", led_chan, 4'h1);
    // attach: qualifier first, then the selected computer
    plug <= 1'b1;
    tick(2);
    chk("mode_to_mux", mode_to_mux, 1'h0);
    cur = 4'h1;
    wait_mux(cur);
    chk("mode_to_mux", mode_to_mux, 1'h1);
    // channel change cuts and drains the supply
    press(0, 4'h4);
    tick(1);
    chk("vbus_en", vbus_en, 1'h0);
    chk("discharge", vbus_discharge, 1'h1);
    chk("led_chan", led_chan, 4'h4);
    cur = 4'h4;
    wait_mux(cur);
    // freeze holds routing and supply
    press(1, 4'h0);
    tick(1);
    chk("led_freeze", led_freeze, 1'h1);
    press(0, 4'h2);
    tick(8);
    chk("led_chan", led_chan, cur);
    chk("vbus_en", vbus_en, 1'h1);
    chk("mux_sel", mux_sel, cur);
    press(1, 4'h0);
    tick(1);
    chk("led_freeze", led_freeze, 1'h0);
    // random descriptors rechecked in session
    for (int n = 0; n < 10; n++) begin
      k = rej_n;
      r = $random(seed);
      desc = mk(r[0] ? CARD_CLASS : r[15:8], r[31:16], 16'h0001,
        r[1] ? (r[2] ? CARD_REV_A : CARD_REV_B) : r[31:16], r[3] | r[4]);
      ok = card_ok(desc);
      reenum();
      chk("mux_sel", mux_sel, ok ? cur : 4'h0);
      chk("rejects", rej_n - k, ok ? 0 : 1);
      if (!ok) begin
        chk("mode_to_mux", mode_to_mux, 1'h0);
        desc = mk(CARD_CLASS, r[31:16], 16'h0002, CARD_REV_B, 1'b1);
        plug <= 1'b0;
        tick(3);
        plug <= 1'b1;
        wait_mux(cur);
      end
    end
    // configurable mode needs admin and a loaded list
    rd(8'h40);
    chk("unmapped", rd_d, 32'h0);
    wr(A_CTRL, 32'h1);
    rd(A_CTRL);
    chk("cfg", rd_d[0], 1'h0);
    wr(A_WL_ID, 32'habcd5678);
    wr(A_CRIT, 32'(1 << CR_VID) | 32'(1 << CR_PID));
    admin_auth <= 1'b1;
    wr(A_CTRL, 32'h1);
    rd(A_CTRL);
    chk("cfg", rd_d[0], 1'h1);
    desc = mk(8'h03, 16'habcd, 16'h5678, 16'h0200, 1'b0);
    reenum();
    chk("mux_sel", mux_sel, cur);
    // every white-list criterion enabled (black list left off), then a serial that no longer agrees
    wr(A_WL_CSP, 32'h00030000);
    wr(A_WL_SER, 32'h00000001);
    wr(A_CRIT, 32'h0000003f);
    reenum();
    chk("mux_sel", mux_sel, cur);
    wr(A_WL_SER, 32'h00000002);
    k = rej_n;
    reenum();
    chk("rejects", rej_n - k, 1);
    chk("mux_sel", mux_sel, 4'h0);
    wr(A_WL_SER, 32'h00000001);
    plug <= 1'b0;
    tick(3);
    plug <= 1'b1;
    wait_mux(cur);
    wr(A_TRAFFIC, {28'h0, cur});
    reenum();
    chk("mux_sel", mux_sel, 4'h0);
    wr(A_TRAFFIC, 32'h0);
    wr(A_BL_ID, 32'habcd5678);
    wr(A_CRIT, 32'(1 << CR_VID) | 32'(1 << CR_PID) | 32'(1 << CR_BL_EN));
    k = rej_n;
    reenum();
    chk("rejects", rej_n - k, 1);
    // back to the fixed filter: a card device qualifies again
    wr(A_CTRL, 32'h2);
    rd(A_CTRL);
    chk("cfg", rd_d[0], 1'h0);
    desc = mk(CARD_CLASS, 16'h1234, 16'h0001, CARD_REV_B, 1'b1);
    plug <= 1'b0;
    tick(3);
    plug <= 1'b1;
    wait_mux(cur);
    // configurable mode again, so the defaults sequence has work to undo
    wr(A_CTRL, 32'h1);
    rd(A_CTRL);
    chk("cfg", rd_d[0], 1'h1);
    // restore defaults: disconnect, blink, retest, settings cleared
    press(2, 4'h0);
    tick(1);
    chk("led_chan", led_chan, 4'hf);
    chk("mux_sel", mux_sel, 4'h0);
    tick(5);
    chk("led_chan", led_chan, 4'h0);
    k = st_n;
    for (int i = 0; i < 100 && st_n == k; i++) tick(1);
    chk("retest", st_n - k, 1);
    tick(1);
    chk("led_chan", led_chan, 4'h0);
    desc = mk(CARD_CLASS, 16'h1234, 16'h0001, CARD_REV_A, 1'b1);
    press(3, 4'h1);
    tick(3);
    chk("led_chan", led_chan, 4'h1);
    rd(A_CTRL);
    chk("cfg", rd_d[0], 1'h0);
    // failed self-test isolates and logs
    reset_dut();
    press(3, 4'h0);
    tick(3);
    chk("fail_log", fail_n, 1);
    chk("led_chan", led_chan, 4'h0);
    chk("vbus_en", vbus_en, 1'h0);
    press(0, 4'h2);
    tick(2);
    chk("mux_sel", mux_sel, 4'h0);
    // tamper cuts every path
    reset_dut();
    press(3, 4'h1);
    wait_mux(4'h1);
    tamper <= 1'b1;
    tick(3);
    chk("mux_sel", mux_sel, 4'h0);
    chk("led_chan", led_chan, 4'h0);
    final_report();
  end
endmodule
